// ---- core/incskip_pkg.sv ----
// Package for the increment and skip execute block.
// Assumes a 14-bit opcode word and 8-bit file registers.
package incskip_pkg;

   // ---------------------------------------------------------------
   // Opcode layout
   // ---------------------------------------------------------------
   localparam int OPCODE_W      = 14;
   localparam int DATA_W        = 8;
   localparam int ADDR_W        = 7;
   localparam int DEST_BIT      = 7;
   localparam int OP_HI         = 13;
   localparam int OP_LO         = 8;
   localparam logic [5:0] OP_INCREMENT      = 6'h0A;
   localparam logic [5:0] OP_INCREMENT_SKIP = 6'h0F;
   localparam logic [5:0] OP_DECREMENT_SKIP = 6'h0B;
   localparam logic [7:0] ONE_VALUE         = 8'h01;
   localparam logic [7:0] ZERO_VALUE        = 8'h00;

   typedef enum logic [1:0] {
      EXEC_NONE,
      EXEC_INCREMENT,
      EXEC_INCREMENT_SKIP,
      EXEC_DECREMENT_SKIP
   } exec_kind_t;

   typedef enum {
      ST_RUN,
      ST_FLUSH
   } skip_state_t;

endpackage

// ---- core/incskip_alu.sv ----
// Opcode classifier and arithmetic for the three file-register operations.
// Assumes a same-clock opcode and operand; purely combinational.
`timescale 1ns/100ps
module incskip_alu
   import incskip_pkg::*;
(
   input  wire logic [OPCODE_W-1:0] i_opcode,
   input  wire logic [DATA_W-1:0]   i_operand,
   output exec_kind_t               o_kind,
   output logic [DATA_W-1:0]        o_result,
   output logic                     o_zero
);

   always_comb begin
      unique case (i_opcode[OP_HI:OP_LO])
         OP_INCREMENT:      o_kind = EXEC_INCREMENT;
         OP_INCREMENT_SKIP: o_kind = EXEC_INCREMENT_SKIP;
         OP_DECREMENT_SKIP: o_kind = EXEC_DECREMENT_SKIP;
         default:           o_kind = EXEC_NONE;
      endcase
   end

   always_comb begin
      if (o_kind == EXEC_DECREMENT_SKIP) begin
         o_result = i_operand - ONE_VALUE;
      end else begin
         o_result = i_operand + ONE_VALUE;
      end
      o_zero = (o_result == ZERO_VALUE);
   end

endmodule // incskip_alu

// ---- core/increment_skip_execute.sv ----
// Execute stage for increment, increment-skip and decrement-skip.
// Assumes the fetch stage presents one opcode per cycle with a valid flag,
// the file array returns read data for o_FILE_ADDR in the same cycle,
// and the program counter advances on its own; a flush discards one word.
//
// How it works
// - Increment opcode adds one to the file register and updates the zero flag.
// - Destination bit zero writes working register, one writes the file register.
// - Increment-skip adds one, skips next word on zero, leaves flags alone.
// - On zero skip result the fetched word is replaced by a no-operation.
// - Nonzero decrement-skip completes in one cycle, next address follows.
// - Decrement-skip subtracts one, routes by destination, skips when zero.
`timescale 1ns/100ps
module increment_skip_execute
   import incskip_pkg::*;
(
   input  wire logic                          I_CLK,
   input  wire logic                          I_NRST,
   input  wire logic                          i_VALID,
   input  wire logic [incskip_pkg::OPCODE_W-1:0] i_OPCODE,
   input  wire logic [incskip_pkg::DATA_W-1:0]   i_FILE_RDATA,
   output logic [incskip_pkg::ADDR_W-1:0]     o_FILE_ADDR,
   output logic                               o_FILE_WE,
   output logic [incskip_pkg::DATA_W-1:0]     o_FILE_WDATA,
   output logic                               o_W_WE,
   output logic [incskip_pkg::DATA_W-1:0]     o_W_WDATA,
   output logic                               o_ZERO_WE,
   output logic                               o_ZERO_VALUE,
   output logic                               o_SKIP,
   output logic                               o_BUSY_NOP
);

   import incskip_pkg::*;

   // ---------------------------------------------------------------
   // Decode and arithmetic
   // ---------------------------------------------------------------
   exec_kind_t        kind;
   logic [DATA_W-1:0] result;
   logic              zero;
   logic              dest_file;
   logic              live;
   logic              next_skip;
   skip_state_t       state;

   assign o_FILE_ADDR = i_OPCODE[ADDR_W-1:0];
   assign dest_file   = i_OPCODE[DEST_BIT];

   incskip_alu u_alu (
      .i_opcode  (i_OPCODE),
      .i_operand (i_FILE_RDATA),
      .o_kind    (kind),
      .o_result  (result),
      .o_zero    (zero)
   );

   // A word fetched behind a taken skip is never executed.
   assign live      = i_VALID && (state == ST_RUN);
   assign next_skip = live && zero &&
                      (kind == EXEC_INCREMENT_SKIP || kind == EXEC_DECREMENT_SKIP);

   // ---------------------------------------------------------------
   // Skip sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         state <= ST_RUN;
      end else if (next_skip) begin
         state <= ST_FLUSH;
      end else if (i_VALID) begin
         state <= ST_RUN;
      end
   end

   assign o_BUSY_NOP = (state == ST_FLUSH);
   assign o_SKIP     = next_skip;

   // ---------------------------------------------------------------
   // Result routing and status
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         o_FILE_WE    <= 1'b0;
         o_W_WE       <= 1'b0;
         o_FILE_WDATA <= ZERO_VALUE;
         o_W_WDATA    <= ZERO_VALUE;
      end else begin
         o_FILE_WE    <= live && (kind != EXEC_NONE) && dest_file;
         o_W_WE       <= live && (kind != EXEC_NONE) && !dest_file;
         o_FILE_WDATA <= result;
         o_W_WDATA    <= result;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         o_ZERO_WE    <= 1'b0;
         o_ZERO_VALUE <= 1'b0;
      end else begin
         // Skip forms leave the status register untouched.
         o_ZERO_WE    <= live && (kind == EXEC_INCREMENT);
         o_ZERO_VALUE <= zero;
      end
   end

   // ---------------------------------------------------------------
   // Result and status checks
   // ---------------------------------------------------------------
   // Results land one cycle after the opcode, so the checks look one cycle on.
   // The operand is taken with $past because the file array answers combinationally.

   a_zero_on_inc: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT |=>
         o_ZERO_WE && o_ZERO_VALUE == $past(zero))
      else $error("increment did not update zero flag");

   a_inc_value: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT |=>
         o_W_WDATA == $past(i_FILE_RDATA) + ONE_VALUE)
      else $error("increment result wrong");

   a_inc_no_skip: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT |->
         !o_SKIP ##1 !o_BUSY_NOP)
      else $error("plain increment requested a skip");

   a_dest_file: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind != EXEC_NONE && dest_file |=>
         o_FILE_WE && !o_W_WE)
      else $error("file destination not written");

   a_dest_work: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind != EXEC_NONE && !dest_file |=>
         o_W_WE && !o_FILE_WE)
      else $error("working destination not written");

   a_same_wdata: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      o_FILE_WE || o_W_WE |->
         o_FILE_WDATA == o_W_WDATA)
      else $error("destinations carry different results");

   a_skip_no_flag: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT_SKIP |=>
         !o_ZERO_WE)
      else $error("skip form touched status");

   a_inc_skip_value: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT_SKIP |=>
         o_FILE_WDATA == $past(i_FILE_RDATA) + ONE_VALUE)
      else $error("increment skip result wrong");

   a_dec_value: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_DECREMENT_SKIP |=>
         o_FILE_WDATA == $past(i_FILE_RDATA) - ONE_VALUE)
      else $error("decrement result wrong");

   a_dec_no_flag: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_DECREMENT_SKIP |=>
         !o_ZERO_WE)
      else $error("decrement skip touched status");

   a_skip_when_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_DECREMENT_SKIP && zero |->
         o_SKIP)
      else $error("zero decrement did not skip");

   a_addr_field: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      o_FILE_ADDR == i_OPCODE[ADDR_W-1:0])
      else $error("file address not from opcode");

   a_foreign_ignored: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_NONE |=>
         !o_FILE_WE && !o_W_WE && !o_ZERO_WE)
      else $error("foreign opcode wrote a result");

   // ---------------------------------------------------------------
   // Skip and discard checks
   // ---------------------------------------------------------------
   // The skip instruction still writes its own result in the next cycle;
   // only the word behind it is dropped, so the quiet cycle is the one after.

   a_skip_flush: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      o_SKIP |=>
         o_BUSY_NOP ##1 !o_FILE_WE && !o_W_WE && !o_ZERO_WE)
      else $error("fetched word not discarded");

   a_flush_quiet: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      o_BUSY_NOP && i_VALID |=>
         !o_FILE_WE && !o_W_WE && !o_ZERO_WE && !o_BUSY_NOP)
      else $error("discarded word was executed");

   a_no_skip_nonzero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_DECREMENT_SKIP && !zero |->
         !o_SKIP ##1 !o_BUSY_NOP)
      else $error("nonzero decrement skipped");

   // Reset must leave no stray write behind, whatever the fetch side shows.
   a_reset_quiet: assert property (@(posedge I_CLK)
      !I_NRST |=>
         !o_FILE_WE && !o_W_WE && !o_ZERO_WE && !o_BUSY_NOP)
      else $error("write or discard pending after reset");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   c_inc_skip: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      o_SKIP && kind == EXEC_INCREMENT_SKIP);
   c_dec_skip: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      o_SKIP && kind == EXEC_DECREMENT_SKIP);
   c_inc_wrap: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      live && kind == EXEC_INCREMENT && zero);
   c_back_to_back: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      o_FILE_WE ##1 o_FILE_WE);
   c_flush_refused: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      o_BUSY_NOP && i_VALID);

endmodule // increment_skip_execute

// ---- verif/file_array_model.sv ----
// Behavioural file register array standing beside the execute block.
// Assumes reads answer in the same cycle and writes trail the opcode by one cycle.
`timescale 1ns/100ps
module file_array_model
   import incskip_pkg::*;
(
   input  wire logic                          i_clk,
   input  wire logic                          i_we,
   input  wire logic [incskip_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [incskip_pkg::DATA_W-1:0] i_wdata,
   output logic      [incskip_pkg::DATA_W-1:0] o_rdata
);
   logic [DATA_W-1:0] mem [128];
   logic [ADDR_W-1:0] last_addr = '0;
   assign o_rdata = mem[i_addr];
   // The write enable arrives a cycle after the address, so the address is held for it.
   always @(posedge i_clk) begin
      last_addr <= i_addr;
      if (i_we) begin
         mem[last_addr] <= i_wdata;
      end
   end
endmodule // file_array_model

// ---- verif/test_increment_skip_execute.sv ----
// Self-checking bench for the increment and skip execute block.
// Assumes the file array model answers reads in the same cycle.
`timescale 1ns/100ps
module test_increment_skip_execute;
   import incskip_pkg::*;
   logic                I_CLK = 1'b0;
   logic                I_NRST = 1'b0;
   logic                i_VALID = 1'b0;
   logic [OPCODE_W-1:0] i_OPCODE = 14'h0000;
   logic [DATA_W-1:0]   rdata, fwd, wwd;
   logic [ADDR_W-1:0]   addr;
   logic                fwe, wwe, zwe, zval, skip, nop;
   int                  fails = 0;
   int                  checks = 0;
   int                  seed = 71552;
   logic [5:0]          ops [4] = '{OP_INCREMENT, OP_INCREMENT_SKIP, OP_DECREMENT_SKIP, 6'h08};
   logic [7:0]          vals [3] = '{8'hFF, 8'h01, 8'h00};
   always #50 I_CLK = ~I_CLK;
   increment_skip_execute increment_skip_execute_i (.I_CLK(I_CLK), .I_NRST(I_NRST),
      .i_VALID(i_VALID), .i_OPCODE(i_OPCODE), .i_FILE_RDATA(rdata), .o_FILE_ADDR(addr),
      .o_FILE_WE(fwe), .o_FILE_WDATA(fwd), .o_W_WE(wwe), .o_W_WDATA(wwd), .o_ZERO_WE(zwe),
      .o_ZERO_VALUE(zval), .o_SKIP(skip), .o_BUSY_NOP(nop));
   file_array_model file_array_model_i (.i_clk(I_CLK), .i_we(fwe), .i_addr(addr),
      .i_wdata(fwd), .o_rdata(rdata));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   function automatic logic [7:0] expect_result(input logic [5:0] op, input logic [7:0] v);
      return (op == OP_DECREMENT_SKIP) ? v - ONE_VALUE : v + ONE_VALUE;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // A zero skip is followed by a valid word aimed at the same register to prove it is dropped.
   task automatic run(input logic [5:0] op, input logic d, input logic [7:0] v);
      logic [6:0] a;
      logic [7:0] r;
      logic       rec;
      logic       z;
      a = 7'($random(seed));
      r = expect_result(op, v);
      rec = op inside {OP_INCREMENT, OP_INCREMENT_SKIP, OP_DECREMENT_SKIP};
      z = rec && op != OP_INCREMENT && r == ZERO_VALUE;
      file_array_model_i.mem[a] = v;
      @(posedge I_CLK);
      #1 i_VALID = 1'b1;
      i_OPCODE = {op, d, a};
      #1 cmp(skip, z, "skip request");
      cmp(addr, a, "file address");
      @(posedge I_CLK);
      #1 i_VALID = z;
      i_OPCODE = {OP_INCREMENT, 1'b1, a};
      cmp(fwe, rec && d, "file write");
      cmp(wwe, rec && !d, "working write");
      cmp(zwe, op == OP_INCREMENT, "zero update");
      cmp(nop, z, "discard cycle");
      if (rec) cmp(d ? fwd : wwd, r, "result");
      if (op == OP_INCREMENT) cmp(zval, r == ZERO_VALUE, "zero flag");
      @(posedge I_CLK);
      #1 i_VALID = 1'b0;
      cmp(fwe | wwe, 1'b0, "write after skip or idle");
      cmp(nop, 1'b0, "single discard");
      cmp(file_array_model_i.mem[a], rec && d ? r : v, "file content");
   endtask
   initial begin
      repeat (2) @(posedge I_CLK);
      #1 I_NRST = 1'b1;
      cmp(nop, 1'b0, "reset discard");
      for (int i = 0; i < 24; i++) begin
         run(ops[i % 4], i >= 12, vals[(i / 4) % 3]);
      end
      $display("corner sweep done");
      for (int i = 0; i < 40; i++) begin
         run(ops[i % 4], 1'($random(seed)), 8'($random(seed)));
      end
      $display("random sweep done");
      tally_and_finish();
   end
endmodule // test_increment_skip_execute
